// File: rtl/sbp_pkg.sv
// shared constants and carrier types for the seven-bit port
package sbp_pkg;
  localparam int unsigned NPIN = 7;
  localparam int unsigned AW = 16;
  localparam int unsigned DW = 8;
  // register byte addresses
  localparam logic [15:0] ADDR_DIR = 16'hffb9;
  localparam logic [15:0] ADDR_LATCH = 16'hffbb;
  localparam logic [15:0] ADDR_PULLUP = 16'hfff2;
  // reset values and fixed read values
  localparam logic [7:0] RST_DIR = 8'h80;
  localparam logic [7:0] RST_LATCH = 8'h80;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  localparam logic [7:0] RD_DIR = 8'hff;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // field positions
  localparam int unsigned BIT_TOP = 7;
  localparam int unsigned PIN_VSYNC = 2;
  localparam int unsigned PIN_TMR_B = 2;
  localparam int unsigned PIN_TMR_A = 1;
  localparam int unsigned PIN_TMR_CLK = 0;
  localparam int unsigned PIN_CAPTURE = 3;
  localparam int unsigned PIN_REQ_LO = 4;
  localparam int unsigned NREQ = 3;
  localparam int unsigned NKEY = 4;
  localparam int unsigned PU_OTHER_LO = 4;
  // input synchroniser depth
  localparam int unsigned SYNC_STAGES = 3;

  // register bus request
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } sbp_bus_s;

  // controls from the timer and timer-connection logic
  typedef struct packed {
    logic sync_out_enable;
    logic vsync_out;
    logic timer_b_out_enable;
    logic timer_out_b;
    logic timer_a_out_enable;
    logic timer_out_a;
    logic timer_clk_ext;
  } sbp_periph_s;

  // levels forwarded to the timer, key-sense and request logic
  typedef struct packed {
    logic timer_clock_in;
    logic timer_capture_in;
    logic vsync_in;
    logic [NKEY-1:0] key_sense_in;
    logic [NREQ-1:0] ext_request_n;
  } sbp_fwd_s;
endpackage

// File: rtl/sbp_port.sv
// seven-bit general-purpose port with key-sense read redirection and pull-ups
// How it works
// - direction bit 1 drives the pin, 0 leaves it an input
// - direction register is write-only; every read returns all ones
// - direction resets to 80 on reset and hardware standby, kept in soft standby
// - output pins keep driving when software standby is entered
// - soft standby drops peripheral ownership; pins return to direction/latch control
// - latch holds pins 6..0; bit 7 ignores writes and reads as set out below
// - reading an output pin returns the latch value
// - reading an input pin returns the pin level, even under peripheral use
// - latch resets to 80 on reset and hardware standby, kept in soft standby
// - input bits 6..4 read own pin if mask 1, else other-port pins 2..0
// - bit 7 reads other-port pin 3 if mask 7 is 0, else one
// - pull-up bits 7..4 serve other-port pins 3..0, bits 3..0 own pins 3..0
// - a pull-up is on only for a pin whose direction bit is 0 and whose control bit is set
// - pull-up control resets to 00 on reset and hardware standby, kept in soft standby
// - pins 6..4 feed requests 2..0, each usable only when its enable is set
// - pin multiplexing is identical in every operating mode
// - pin 2: vsync out if enabled, else timer out b if enabled, else direction
// - pin 0 timer clock is used only when an external clock is selected
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module sbp_port
  import sbp_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // standby controls
  input wire logic hw_standby,
  input wire logic sw_standby,
  // register port
  input wire sbp_pkg::sbp_bus_s bus,
  output logic [sbp_pkg::DW-1:0] rdata,
  // own pins
  input wire logic [sbp_pkg::NPIN-1:0] pin_in,
  output logic [sbp_pkg::NPIN-1:0] pin_out,
  output logic [sbp_pkg::NPIN-1:0] pin_oe,
  output logic [sbp_pkg::NKEY-1:0] pullup_on,
  // other-port pins and their direction
  input wire logic [sbp_pkg::NKEY-1:0] other_pin_in,
  input wire logic [sbp_pkg::NKEY-1:0] other_port_direction,
  output logic [sbp_pkg::NKEY-1:0] other_pullup_on,
  // key-sense mask bits 7..4 and request enables
  input wire logic [sbp_pkg::NKEY-1:0] keysense_mask,
  input wire logic [sbp_pkg::NREQ-1:0] request_enable,
  // peripheral side
  input wire sbp_pkg::sbp_periph_s periph,
  output sbp_pkg::sbp_fwd_s fwd,
  output logic periph_init
);
  import sbp_pkg::*;

  // timing seen from software:
  // - a register write lands at the edge that samples its strobe
  // - pin drive and pull-ups follow one edge after the register edge
  // - read data stand only in the cycle after the read strobe, zero otherwise
  // - a pin change reaches a port read about four edges later, three
  //   synchroniser stages plus the agreement filter
  // - with ce low only reset and hardware standby move anything, and a strobe in such a cycle is lost
  // hardware standby behaves like reset on the three registers only; soft
  // standby keeps them, takes the pins back from the peripherals and holds the peripherals in init

  // registers
  logic [NPIN-1:0] dir_ff, nxt_dir;
  logic [NPIN-1:0] latch_ff, nxt_latch;
  logic [DW-1:0] pullup_ff, nxt_pullup;
  logic [DW-1:0] rdata_ff, nxt_rdata;

  // synchronisers: stage 1 feeds only stage 2
  logic [NPIN-1:0] ps1_ff, ps2_ff, ps3_ff, pf_ff, nxt_pf;
  logic [NKEY-1:0] os1_ff, os2_ff, os3_ff, of_ff, nxt_of;

  // pin drivers
  logic [NPIN-1:0] out_ff, nxt_out, oe_ff, nxt_oe;
  logic [NKEY-1:0] pu_ff, nxt_pu, opu_ff, nxt_opu;
  sbp_fwd_s fwd_ff, nxt_fwd;
  logic init_ff, nxt_init;

  logic clear;
  logic [2:0] sel;
  logic [DW-1:0] port_value;

  // filtered level of one pin: follow only once the last two stages agree,
  // so a sample caught mid-transition can never flip the level by itself
  function automatic logic agree(input logic a,
                                 input logic b,
                                 input logic held);
    agree = (a == b) ? b : held;
  endfunction

  // register decode shared by the write and read paths: {pull-up, latch, direction}
  function automatic logic [2:0] reg_sel(input logic [AW-1:0] addr);
    reg_sel = 3'h0;
    if (addr == ADDR_DIR) begin
      reg_sel[0] = 1'b1;
    end
    if (addr == ADDR_LATCH) begin
      reg_sel[1] = 1'b1;
    end
    if (addr == ADDR_PULLUP) begin
      reg_sel[2] = 1'b1;
    end
  endfunction

  assign clear = reset | hw_standby;
  assign sel = reg_sel(bus.addr);

  // register writes; soft standby does not disturb them
  always_comb begin
    nxt_dir = dir_ff;
    nxt_latch = latch_ff;
    nxt_pullup = pullup_ff;
    // unmapped addresses fall through and change nothing
    if (bus.wr) begin
      if (sel[0]) begin
        nxt_dir = bus.wdata[NPIN-1:0];
      end
      if (sel[1]) begin
        nxt_latch = bus.wdata[NPIN-1:0];
      end
      if (sel[2]) begin
        nxt_pullup = bus.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (clear) begin
      dir_ff <= RST_DIR[NPIN-1:0];
      latch_ff <= RST_LATCH[NPIN-1:0];
      pullup_ff <= RST_PULLUP;
    end else if (ce) begin
      dir_ff <= nxt_dir;
      latch_ff <= nxt_latch;
      pullup_ff <= nxt_pullup;
    end
  end

  // input filters, one per own pin
  for (genvar g = 0; g < NPIN; g++) begin : g_pin_filter
    assign nxt_pf[g] = agree(ps2_ff[g], ps3_ff[g], pf_ff[g]);
  end

  // input filters, one per other-port pin
  for (genvar h = 0; h < NKEY; h++) begin : g_other_filter
    assign nxt_of[h] = agree(os2_ff[h], os3_ff[h], of_ff[h]);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ps1_ff <= '0;
      ps2_ff <= '0;
      ps3_ff <= '0;
      pf_ff <= '0;
      os1_ff <= '0;
      os2_ff <= '0;
      os3_ff <= '0;
      of_ff <= '0;
    end else if (ce) begin
      ps1_ff <= pin_in;
      ps2_ff <= ps1_ff;
      ps3_ff <= ps2_ff;
      pf_ff <= nxt_pf;
      os1_ff <= other_pin_in;
      os2_ff <= os1_ff;
      os3_ff <= os2_ff;
      of_ff <= nxt_of;
    end
  end

  // port read value, one bit per pin
  for (genvar i = 0; i < NPIN; i++) begin : g_read_bit
    if (i >= PIN_REQ_LO) begin : g_keyed
      // an input bit may be redirected to the matching other-port pin
      assign port_value[i] = dir_ff[i] ? latch_ff[i] :
        keysense_mask[i-PIN_REQ_LO] ? pf_ff[i] : of_ff[i-PIN_REQ_LO];
    end else begin : g_plain
      assign port_value[i] = dir_ff[i] ? latch_ff[i] : pf_ff[i];
    end
  end

  // top bit has no pin of its own
  assign port_value[BIT_TOP] = keysense_mask[NKEY-1] ? 1'b1 : of_ff[NKEY-1];

  // read data stand for exactly the cycle after the strobe
  always_comb begin
    nxt_rdata = '0;
    if (bus.rd) begin
      nxt_rdata = RD_UNMAPPED;
      if (sel[0]) begin
        nxt_rdata = RD_DIR;
      end
      if (sel[1]) begin
        nxt_rdata = port_value;
      end
      if (sel[2]) begin
        nxt_rdata = pullup_ff;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_ff <= '0;
    end else if (ce) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // pin drivers; no mode input reaches this mux
  always_comb begin
    nxt_out = latch_ff;
    nxt_oe = dir_ff;
    // in soft standby the peripherals are held in init and lose the pins
    if (!sw_standby) begin
      if (periph.sync_out_enable) begin
        nxt_out[PIN_VSYNC] = periph.vsync_out;
        nxt_oe[PIN_VSYNC] = 1'b1;
      end else if (periph.timer_b_out_enable) begin
        nxt_out[PIN_TMR_B] = periph.timer_out_b;
        nxt_oe[PIN_TMR_B] = 1'b1;
      end
      if (periph.timer_a_out_enable) begin
        nxt_out[PIN_TMR_A] = periph.timer_out_a;
        nxt_oe[PIN_TMR_A] = 1'b1;
      end
    end
    nxt_init = sw_standby;
  end

  // pull-ups follow the direction bits, not the peripheral drive; a pin
  // taken by a timer output may therefore keep its pull-up on
  for (genvar j = 0; j < NKEY; j++) begin : g_pullup
    assign nxt_pu[j] = ~dir_ff[j] & pullup_ff[j];
    assign nxt_opu[j] = ~other_port_direction[j] & pullup_ff[j+PU_OTHER_LO];
  end

  // forwarded levels
  always_comb begin
    nxt_fwd.key_sense_in = pf_ff[NKEY-1:0];
    nxt_fwd.timer_capture_in = pf_ff[PIN_CAPTURE];
    nxt_fwd.vsync_in = pf_ff[PIN_CAPTURE];
    // an idle low keeps an internal clock selection free of pin noise
    nxt_fwd.timer_clock_in = periph.timer_clk_ext & pf_ff[PIN_TMR_CLK];
    for (int k = 0; k < NREQ; k++) begin
      // disabled requests sit at the inactive high level
      nxt_fwd.ext_request_n[k] = ~request_enable[k] | pf_ff[k+PIN_REQ_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      out_ff <= '0;
      oe_ff <= '0;
      pu_ff <= '0;
      opu_ff <= '0;
      fwd_ff <= '0;
      init_ff <= 1'b0;
    end else if (ce) begin
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      pu_ff <= nxt_pu;
      opu_ff <= nxt_opu;
      fwd_ff <= nxt_fwd;
      init_ff <= nxt_init;
    end
  end

  assign rdata = rdata_ff;
  assign pin_out = out_ff;
  assign pin_oe = oe_ff;
  assign pullup_on = pu_ff;
  assign other_pullup_on = opu_ff;
  assign fwd = fwd_ff;
  assign periph_init = init_ff;
endmodule // sbp_port

// File: verif/sbp_board.sv
// board model that applies pin levels to the port
`timescale 1ns/1ps
module sbp_board (
  // port drive
  input wire logic [6:0] pin_out,
  input wire logic [6:0] pin_oe,
  // levels the board puts on undriven pins
  input wire logic [6:0] ext,
  output logic [6:0] pin_in
);
  // a driven pin reads back the port's own level, the rest take the board level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule // sbp_board

// File: verif/sbp_port_sva.sv
// concurrent checks on the seven-bit port
`timescale 1ns/1ps
module sbp_port_sva
  import sbp_pkg::*;
(
  // clock and controls
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic hw_standby,
  input wire logic sw_standby,
  // register port
  input wire sbp_pkg::sbp_bus_s bus,
  input wire logic [7:0] rdata,
  // pins and side inputs
  input wire logic [6:0] pin_out,
  input wire logic [6:0] pin_oe,
  input wire logic [3:0] pullup_on,
  input wire logic [3:0] other_pullup_on,
  input wire logic [3:0] keysense_mask,
  input wire logic [2:0] request_enable,
  input wire sbp_pkg::sbp_periph_s periph,
  input wire sbp_pkg::sbp_fwd_s fwd,
  input wire logic periph_init
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  rd_idle_a: assert property (ce && !bus.rd |=> rdata == 8'h00)
    else $error("rdata not zero outside a read");
  dir_read_a: assert property (bus.rd && ce && bus.addr == ADDR_DIR |=> rdata == 8'hff)
    else $error("direction read not all ones");
  top_bit_a: assert property (bus.rd && ce && bus.addr == ADDR_LATCH && keysense_mask[3]
    |=> rdata[7]) else $error("bit 7 not one under mask");
  pullup_gate_a: assert property ((pullup_on & pin_oe[3:0] & 4'h9) == 4'h0)
    else $error("pull-up on a driving pin");
  standby_init_a: assert property (ce && sw_standby |=> periph_init)
    else $error("no peripheral init in standby");
  req_off_a: assert property (ce && !request_enable[0] |=> fwd.ext_request_n[0])
    else $error("disabled request active");
  tclk_off_a: assert property (ce && !periph.timer_clk_ext |=> !fwd.timer_clock_in)
    else $error("timer clock with internal source");
  vsync_drive_a: assert property (ce && !sw_standby && periph.sync_out_enable
    |=> pin_oe[2] && pin_out[2] == $past(periph.vsync_out))
    else $error("pin 2 not carrying sync");
  hw_pullup_a: assert property (hw_standby ##1 (hw_standby && ce)
    |=> pullup_on == 4'h0 && other_pullup_on == 4'h0)
    else $error("pull-ups on in hardware standby");
endmodule // sbp_port_sva
bind sbp_port sbp_port_sva sbp_port_sva_i (.clk, .reset, .ce, .hw_standby, .sw_standby,
  .bus, .rdata, .pin_out, .pin_oe, .pullup_on, .other_pullup_on, .keysense_mask,
  .request_enable, .periph, .fwd, .periph_init);

// File: verif/sbp_port_test.sv
// self-checking bench for the seven-bit port
`timescale 1ns/1ps
module sbp_port_test;
  import sbp_pkg::*;
  logic clk, reset, ce, hw_standby, sw_standby, periph_init, rd_d;
  sbp_bus_s bus;
  sbp_periph_s periph;
  sbp_fwd_s fwd;
  logic [7:0] rdata, d, l, p;
  logic [6:0] pin_in, pin_out, pin_oe, e, lv;
  logic [3:0] pullup_on, other_pin_in, other_port_direction, other_pullup_on, keysense_mask;
  logic [2:0] request_enable;
  logic [7:0] q[$];
  int err_total, n_compared;
  sbp_port sbp_port_i (.clk(clk), .reset(reset), .ce(ce), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .bus(bus), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_on(pullup_on), .other_pin_in(other_pin_in),
    .other_port_direction(other_port_direction), .other_pullup_on(other_pullup_on),
    .keysense_mask(keysense_mask), .request_enable(request_enable), .periph(periph),
    .fwd(fwd), .periph_init(periph_init));
  sbp_board sbp_board_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext(e), .pin_in(pin_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] v);
    q.push_back(v);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(posedge clk);
  endtask
  // expected port read, the key-sense mask may redirect undriven upper bits
  function automatic logic [7:0] port_rd(input logic [7:0] dd, input logic [7:0] ll);
    logic [7:0] r;
    r[7] = keysense_mask[3] ? 1'b1 : other_pin_in[3];
    for (int i = 0; i < 7; i++) begin
      r[i] = dd[i] ? ll[i] : (i >= 4 && !keysense_mask[i-4]) ? other_pin_in[i-4] : e[i];
    end
    return r;
  endfunction
  always @(posedge clk) rd_d <= bus.rd && ce && !reset;
  always @(negedge clk) if (rd_d) cmp(rdata, q.pop_front());
  initial begin
    #200us;
    err_total++;
    print_verdict();
  end
  initial begin
    {reset, ce, hw_standby, sw_standby} = 4'b1100;
    bus = '0;
    periph = '0;
    {e, other_pin_in, other_port_direction, keysense_mask, request_enable} = '0;
    void'($urandom(32'h45d2));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    rd(ADDR_DIR, 8'hff);
    rd(ADDR_PULLUP, 8'h00);
    rd(16'h0000, 8'h00);
    rd(ADDR_LATCH, port_rd(8'h80, 8'h80));
    $display("test reset done");
    repeat (8) begin
      {d, l, p} = 24'($urandom);
      e <= 7'($urandom);
      {other_pin_in, other_port_direction, keysense_mask} <= 12'($urandom);
      request_enable <= 3'($urandom);
      periph.timer_clk_ext <= 1'($urandom);
      wr(ADDR_DIR, d);
      wr(ADDR_LATCH, l);
      wr(ADDR_PULLUP, p);
      repeat (6) @(posedge clk);
      rd(ADDR_LATCH, port_rd(d, l));
      rd(ADDR_PULLUP, p);
      @(negedge clk);
      cmp(pin_oe, d[6:0]);
      cmp(pin_out & d[6:0], l[6:0] & d[6:0]);
      cmp(pullup_on, ~d[3:0] & p[3:0]);
      cmp(other_pullup_on, ~other_port_direction & p[7:4]);
      cmp(fwd.key_sense_in, (d[3:0] & l[3:0]) | (~d[3:0] & e[3:0]));
      lv = (d[6:0] & l[6:0]) | (~d[6:0] & e);
      cmp(fwd.timer_capture_in, lv[3]);
      cmp(fwd.timer_clock_in, periph.timer_clk_ext & lv[0]);
      cmp(fwd.ext_request_n, 3'(~request_enable | lv[6:4]));
      @(posedge clk);
    end
    $display("test random done");
    sw_standby <= 1'b1;
    periph <= '{sync_out_enable: 1'b1, vsync_out: 1'b1, timer_a_out_enable: 1'b1, default: 1'b0};
    repeat (3) @(negedge clk);
    cmp(pin_oe, d[6:0]);
    cmp(periph_init, 1'b1);
    @(posedge clk);
    sw_standby <= 1'b0;
    repeat (3) @(negedge clk);
    cmp({pin_oe[2], pin_out[2]}, 2'b11);
    @(posedge clk);
    periph <= '0;
    hw_standby <= 1'b1;
    repeat (3) @(posedge clk);
    hw_standby <= 1'b0;
    rd(ADDR_PULLUP, 8'h00);
    repeat (6) @(posedge clk);
    rd(ADDR_LATCH, port_rd(8'h80, 8'h80));
    ce <= 1'b0;
    wr(ADDR_PULLUP, 8'h5a);
    ce <= 1'b1;
    rd(ADDR_PULLUP, 8'h00);
    @(negedge clk);
    cmp(pin_oe, 7'h00);
    $display("test standby done");
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule // sbp_port_test
